/* rtl/sdcr_pkg.sv */
package sdcr_pkg;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_HZ       = 40_000_000;
  localparam int BAUD_HZ      = 9600;
  localparam int DEF_BAUD_DIV = CLK_HZ / BAUD_HZ;

  // ----------------------------------------------------------------
  // Character codes
  // ----------------------------------------------------------------
  localparam logic [7:0] CH_CR    = 8'h0d;
  localparam logic [7:0] CH_CLEAR = 8'h03;
  localparam logic [7:0] CH_GRAPH = 8'h07;
  localparam logic [7:0] CH_TRIG  = 8'h14;
  localparam logic [7:0] CH_VAR   = 8'h16;
  localparam logic [7:0] CH_LAMP  = 8'h0c;
  localparam logic [7:0] CH_BSL   = 8'h5c;
  localparam logic [7:0] CH_SPACE = 8'h20;
  localparam logic [7:0] CH_QUOTE = 8'h22;
  localparam logic [7:0] CH_MINUS = 8'h2d;
  localparam logic [7:0] CH_ZERO  = 8'h30;
  localparam logic [7:0] CH_NINE  = 8'h39;
  localparam logic [7:0] CH_DOT   = 8'h2e;
  localparam logic [7:0] CH_COLON = 8'h3a;
  localparam logic [7:0] CH_SLASH = 8'h2f;

  // ----------------------------------------------------------------
  // Field limits
  // ----------------------------------------------------------------
  localparam logic [7:0]  NODE_ALL    = 8'h7f;
  localparam logic [7:0]  NODE_FORBID = 8'h0d;
  localparam logic [7:0]  LINE_MAX    = 8'h04;
  localparam logic [7:0]  LINE_ALL    = 8'h32;
  localparam logic [7:0]  SYM_MAX     = 8'h20;
  localparam logic [16:0] MSG_MAX     = 17'h0270f;
  localparam logic [16:0] VAL_POS_MAX = 17'h0ffff;
  localparam logic [16:0] VAL_NEG_MAX = 17'h08000;
  localparam logic [16:0] SLOT_MAX    = 17'h0000a;
  localparam logic [16:0] LAMP_MAX    = 17'h00010;

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_LAMP = 8'h04;
  localparam logic [7:0] REG_TRIG = 8'h08;
  localparam logic [7:0] REG_VAR  = 8'h0c;
  localparam int         CTRL_MODE_LSB = 0;
  localparam int         CTRL_NODE_LSB = 8;
  localparam logic [6:0] NODE_RST      = 7'h01;

  typedef enum logic [1:0] {
    MODE_SLAVE = 2'b00,
    MODE_INPUT = 2'b01,
    MODE_TRIG  = 2'b10
  } sdcr_mode_e;

  typedef struct packed {
    logic       vld;
    logic [7:0] data;
  } sdcr_byte_s;

  typedef struct packed {
    logic       load;
    logic       clr_line;
    logic       clr_all;
    logic       vars_only;
    logic [2:0] line;
    logic [6:0] len;
  } sdcr_slv_evt_s;

  typedef struct packed {
    logic        trig;
    logic        var_wr;
    logic [13:0] msg;
    logic [3:0]  slot;
    logic        is_text;
    logic [16:0] val;
  } sdcr_cmd_evt_s;

endpackage : sdcr_pkg

/* rtl/sdcr_uart_rx.sv */
`timescale 1ns/1ps
`default_nettype none
module sdcr_uart_rx
  import sdcr_pkg::*;
#(
  parameter int DIV = DEF_BAUD_DIV
)(
  input  wire logic   mclk_i,
  input  wire logic   rst_i,
  input  wire logic   rxd_i,
  output sdcr_byte_s  byte_o
);

  localparam int CW = $clog2(DIV + 1);

  typedef enum logic [1:0] {
    RX_IDLE  = 2'b00,
    RX_START = 2'b01,
    RX_DATA  = 2'b10,
    RX_STOP  = 2'b11
  } sdcr_rx_e;

  typedef struct packed {
    logic [2:0]    sync;
    logic          level;
    sdcr_rx_e      st;
    logic [CW-1:0] cnt;
    logic [2:0]    bitn;
    logic [7:0]    sh;
    sdcr_byte_s    out;
  } sdcr_rx_s;

  sdcr_rx_s s_ff;
  sdcr_rx_s nxt_s;

  // ----------------------------------------------------------------
  // Sampling and framing
  // ----------------------------------------------------------------
  always_comb
  begin
    nxt_s         = s_ff;
    nxt_s.out.vld = 1'b0;
    nxt_s.sync    = {s_ff.sync[1:0], rxd_i};
    if (s_ff.sync[1] == s_ff.sync[2])
    begin
      nxt_s.level = s_ff.sync[2];
    end
    if (s_ff.st == RX_IDLE)
    begin
      if (!s_ff.level)
      begin
        nxt_s.st  = RX_START;
        nxt_s.cnt = CW'(DIV / 2);
      end
    end
    else if (s_ff.cnt != '0)
    begin
      nxt_s.cnt = s_ff.cnt - CW'(1);
    end
    else
    begin
      nxt_s.cnt = CW'(DIV - 1);
      case (s_ff.st)
        RX_START:
        begin
          nxt_s.st   = s_ff.level ? RX_IDLE : RX_DATA;
          nxt_s.bitn = 3'h0;
        end
        RX_DATA:
        begin
          nxt_s.sh   = {s_ff.level, s_ff.sh[7:1]};
          nxt_s.bitn = s_ff.bitn + 3'h1;
          if (s_ff.bitn == 3'h7)
          begin
            nxt_s.st = RX_STOP;
          end
        end
        RX_STOP:
        begin
          // Framing error drops the byte
          nxt_s.out.vld  = s_ff.level;
          nxt_s.out.data = s_ff.sh;
          nxt_s.st       = RX_IDLE;
        end
        default:
        begin
          nxt_s.st = RX_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge mclk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      s_ff       <= '0;
      s_ff.sync  <= 3'h7;
      s_ff.level <= 1'b1;
    end
    else
    begin
      s_ff <= nxt_s;
    end
  end

  assign byte_o = s_ff.out;

endmodule : sdcr_uart_rx
`default_nettype wire

/* rtl/sdcr_top.sv */
// Function
// - Packet node 1 to 127, never 13
// - Own node 127 accepts every packet
// - Packet node 127 is broadcast
// - Line 50 with clear blanks all
// - Carriage return ends each packet
// - Entry variables in packets not processed
// - Repeated message refreshes only variables
// - Port mode selects which traffic parsed
// - Trigger command shows addressed message
// - Command node 1-126 single, 127 all
// - Variable write: value, slot, node, CR
// - Numeric values -32768 to +65535
// - Slot 1 to 10, active message
// - Quoted value stored as text
// - Lamp level 0 off, 1 on
// - Leading clear byte blanks named line
// - Byte after introducer is symbol 1-32
// - New message replaces line at once
//
// Added by the designer: the address-and-strobe port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module sdcr_top
  import sdcr_pkg::*;
#(
  parameter int BAUD_DIV = DEF_BAUD_DIV,
  parameter int TXT_LEN  = 16,
  parameter int PKT_LEN  = 100
)(
  input  wire logic                 mclk_i,
  input  wire logic                 rst_i,
  input  wire logic                 rxd_i,
  input  wire logic [7:0]           reg_addr_i,
  input  wire logic [31:0]          reg_wdata_i,
  input  wire logic                 reg_wr_i,
  input  wire logic                 reg_rd_i,
  output logic      [31:0]          reg_rdata_o,
  input  wire logic [6:0]           disp_raddr_i,
  output logic      [7:0]           disp_rdata_o,
  output sdcr_slv_evt_s             slv_evt_o,
  output sdcr_cmd_evt_s             cmd_evt_o,
  output logic      [TXT_LEN*8-1:0] var_text_o,
  output logic      [15:0]          lamp_o
);

  localparam int BUF_LEN = PKT_LEN + 4;
  localparam int PW      = $clog2(BUF_LEN + 1);
  localparam int TW      = $clog2(TXT_LEN + 1);

  typedef enum logic {
    PS_IDLE = 1'b0,
    PS_BODY = 1'b1
  } sdcr_ps_e;

  typedef struct packed {
    sdcr_mode_e                  mode;
    logic [6:0]                  node;
    logic [31:0]                 rdata;
    logic [PW-1:0]               s_cnt;
    logic [7:0]                  s_first;
    logic [7:0]                  s_h1;
    logic [7:0]                  s_h2;
    logic                        s_gfx;
    logic                        s_bad;
    logic [15:0]                 s_sig;
    logic [3:0][15:0]            line_sig;
    logic [3:0]                  line_sig_vld;
    sdcr_slv_evt_s               sevt;
    sdcr_ps_e                    ps;
    logic [7:0]                  cmd;
    logic [1:0]                  nf;
    logic [16:0]                 f0;
    logic                        f0_neg;
    logic                        f0_txt;
    logic [16:0]                 f1;
    logic [16:0]                 cur;
    logic                        cur_dig;
    logic                        cur_neg;
    logic                        cur_txt;
    logic                        q_pend;
    logic                        p_bad;
    logic [TXT_LEN-1:0][7:0]     txt;
    logic [TW-1:0]               tlen;
    sdcr_cmd_evt_s               cevt;
    logic [TXT_LEN-1:0][7:0]     txt_out;
    logic [15:0]                 lamp;
  } sdcr_st_s;

  sdcr_st_s      s_ff;
  sdcr_st_s      nxt_s;
  sdcr_byte_s    rx_byte;
  logic [7:0]    pkt_mem [BUF_LEN];
  logic          mem_we;
  logic [PW-1:0] mem_wa;
  logic [7:0]    disp_rdata_ff;

  function automatic logic is_digit(input logic [7:0] b);
    return (b >= CH_ZERO) && (b <= CH_NINE);
  endfunction : is_digit

  // Characters that belong to a displayed variable, not fixed text
  function automatic logic is_var_char(input logic [7:0] b);
    return is_digit(b) || (b == CH_MINUS) || (b == CH_DOT) || (b == CH_COLON)
           || (b == CH_SLASH) || (b == CH_SPACE);
  endfunction : is_var_char

  function automatic logic cmd_node_ok(input logic [16:0] v, input logic [6:0] own);
    return (v != '0) && (v <= 17'(NODE_ALL)) && ((v == 17'(NODE_ALL)) || (v[6:0] == own));
  endfunction : cmd_node_ok

  sdcr_uart_rx #(
    .DIV (BAUD_DIV)
  ) u_rx (
    .mclk_i (mclk_i),
    .rst_i  (rst_i),
    .rxd_i  (rxd_i),
    .byte_o (rx_byte)
  );

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb
  begin
    logic [7:0]  b;
    logic [20:0] acc;
    logic        hit;
    logic        ctl3;
    logic [1:0]  li;
    logic        close;
    logic        ok;
    b      = rx_byte.data;
    acc    = '0;
    hit    = 1'b0;
    ctl3   = 1'b0;
    li     = 2'h0;
    close  = 1'b0;
    ok     = 1'b0;
    mem_we = 1'b0;
    mem_wa = s_ff.s_cnt;
    nxt_s  = s_ff;
    nxt_s.sevt.load      = 1'b0;
    nxt_s.sevt.clr_line  = 1'b0;
    nxt_s.sevt.clr_all   = 1'b0;
    nxt_s.cevt.trig      = 1'b0;
    nxt_s.cevt.var_wr    = 1'b0;
    nxt_s.rdata          = '0;

    // Register port
    if (reg_wr_i && (reg_addr_i == REG_CTRL))
    begin
      nxt_s.mode = sdcr_mode_e'(reg_wdata_i[CTRL_MODE_LSB +: 2]);
      nxt_s.node = reg_wdata_i[CTRL_NODE_LSB +: 7];
    end
    if (reg_rd_i)
    begin
      case (reg_addr_i)
        REG_CTRL: nxt_s.rdata = {17'h0, s_ff.node, 6'h0, s_ff.mode};
        REG_LAMP: nxt_s.rdata = {16'h0, s_ff.lamp};
        REG_TRIG: nxt_s.rdata = {18'h0, s_ff.cevt.msg};
        REG_VAR:  nxt_s.rdata = {10'h0, s_ff.cevt.slot, s_ff.cevt.is_text, s_ff.cevt.val};
        default:  nxt_s.rdata = '0;
      endcase
    end

    // slave traffic only in slave mode
    if (rx_byte.vld && (s_ff.mode == MODE_SLAVE))
    begin
      if (b == CH_CR)
      begin
        ctl3 = (s_ff.s_cnt >= PW'(3)) && (s_ff.s_first == CH_CLEAR);
        hit  = (s_ff.s_cnt >= PW'(2)) && !s_ff.s_bad && !s_ff.s_gfx && (s_ff.s_h2 != 8'h00)
               && !s_ff.s_h2[7] && (s_ff.s_h2 != NODE_FORBID)
               && ((s_ff.node == NODE_ALL[6:0]) || (s_ff.s_h2 == NODE_ALL)
                   || (s_ff.s_h2[6:0] == s_ff.node));
        li   = 2'(s_ff.s_h1 - 8'h01);
        if (hit && ctl3 && (s_ff.s_h1 == LINE_ALL))
        begin
          nxt_s.sevt.clr_all   = 1'b1;
          nxt_s.line_sig_vld   = 4'h0;
        end
        else if (hit && (s_ff.s_h1 != 8'h00) && (s_ff.s_h1 <= LINE_MAX))
        begin
          nxt_s.sevt.line = 3'(s_ff.s_h1);
          if (ctl3)
          begin
            nxt_s.sevt.clr_line      = 1'b1;
            nxt_s.line_sig_vld[li]   = 1'b0;
          end
          else
          begin
            nxt_s.sevt.load      = 1'b1;
            nxt_s.sevt.len       = 7'(s_ff.s_cnt - PW'(2));
            nxt_s.sevt.vars_only = s_ff.line_sig_vld[li] && (s_ff.line_sig[li] == s_ff.s_sig);
            nxt_s.line_sig[li]     = s_ff.s_sig;
            nxt_s.line_sig_vld[li] = 1'b1;
          end
        end
        nxt_s.s_cnt = '0;
        nxt_s.s_bad = 1'b0;
        nxt_s.s_gfx = 1'b0;
        nxt_s.s_sig = '0;
        nxt_s.s_h1  = '0;
        nxt_s.s_h2  = '0;
      end
      else
      begin
        // payload is stored, never parsed for entry fields
        if (s_ff.s_cnt < PW'(BUF_LEN))
        begin
          mem_we      = 1'b1;
          nxt_s.s_cnt = s_ff.s_cnt + PW'(1);
        end
        else
        begin
          nxt_s.s_bad = 1'b1;
        end
        if (s_ff.s_cnt == '0)
        begin
          nxt_s.s_first = b;
        end
        if (s_ff.s_gfx)
        begin
          nxt_s.s_gfx = 1'b0;
          if ((b == 8'h00) || (b > SYM_MAX))
          begin
            nxt_s.s_bad = 1'b1;
          end
        end
        else if (b == CH_GRAPH)
        begin
          nxt_s.s_gfx = 1'b1;
        end
        if ((s_ff.s_cnt >= PW'(2)) && !is_var_char(s_ff.s_h2))
        begin
          nxt_s.s_sig = {s_ff.s_sig[14:0], s_ff.s_sig[15]} ^ {8'h00, s_ff.s_h2};
        end
        nxt_s.s_h2 = s_ff.s_h1;
        nxt_s.s_h1 = b;
      end
    end

    if (rx_byte.vld && (s_ff.mode == MODE_TRIG))
    begin
      if ((b == CH_TRIG) || (b == CH_VAR) || (b == CH_LAMP))
      begin
        nxt_s.ps      = PS_BODY;
        nxt_s.cmd     = b;
        nxt_s.nf      = 2'h0;
        nxt_s.cur     = '0;
        nxt_s.cur_dig = 1'b0;
        nxt_s.cur_neg = 1'b0;
        nxt_s.cur_txt = 1'b0;
        nxt_s.q_pend  = 1'b0;
        nxt_s.p_bad   = 1'b0;
        nxt_s.tlen    = '0;
      end
      else
      begin
        case (s_ff.ps)
          PS_IDLE:
          begin
            nxt_s.ps = PS_IDLE;
          end
          PS_BODY:
          begin
            if (b == CH_CR)
            begin
              nxt_s.ps = PS_IDLE;
              // last field must be a plain number
              ok = !s_ff.p_bad && s_ff.cur_dig && !s_ff.cur_txt && !s_ff.cur_neg;
              if (ok && (s_ff.cmd == CH_TRIG) && (s_ff.nf == 2'h1) && cmd_node_ok(s_ff.cur, s_ff.node)
                  && !s_ff.f0_neg && !s_ff.f0_txt && (s_ff.f0 != '0) && (s_ff.f0 <= MSG_MAX))
              begin
                nxt_s.cevt.trig = 1'b1;
                nxt_s.cevt.msg  = s_ff.f0[13:0];
              end
              if (ok && (s_ff.cmd == CH_VAR) && (s_ff.nf == 2'h2) && cmd_node_ok(s_ff.cur, s_ff.node)
                  && (s_ff.f1 != '0) && (s_ff.f1 <= SLOT_MAX)
                  && (s_ff.f0_txt || !s_ff.f0_neg || (s_ff.f0 <= VAL_NEG_MAX)))
              begin
                nxt_s.cevt.var_wr  = 1'b1;
                nxt_s.cevt.slot    = s_ff.f1[3:0];
                nxt_s.cevt.is_text = s_ff.f0_txt;
                nxt_s.cevt.val     = s_ff.f0_neg ? (17'h0 - s_ff.f0) : s_ff.f0;
                nxt_s.txt_out      = s_ff.txt;
              end
              if (ok && (s_ff.cmd == CH_LAMP) && (s_ff.nf == 2'h2) && cmd_node_ok(s_ff.cur, s_ff.node)
                  && !s_ff.f0_txt && !s_ff.f0_neg && (s_ff.f0 != '0) && (s_ff.f0 <= LAMP_MAX)
                  && (s_ff.f1 <= 17'h00001))
              begin
                nxt_s.lamp[4'(s_ff.f0 - 17'h1)] = s_ff.f1[0];
              end
            end
            else if (s_ff.cur_txt)
            begin
              // quoted text, last quote before separator dropped
              if ((b == CH_BSL) && s_ff.q_pend)
              begin
                nxt_s.tlen = s_ff.tlen - TW'(1);
                close      = 1'b1;
              end
              else if (s_ff.tlen < TW'(TXT_LEN))
              begin
                nxt_s.txt[s_ff.tlen[TW-1:0]] = b;
                nxt_s.tlen                   = s_ff.tlen + TW'(1);
                nxt_s.q_pend                 = (b == CH_QUOTE);
              end
              else
              begin
                nxt_s.p_bad = 1'b1;
              end
            end
            else if (b == CH_BSL)
            begin
              close = 1'b1;
            end
            else if (b == CH_SPACE)
            begin
              nxt_s.ps = PS_BODY;
            end
            else if ((b == CH_QUOTE) && (s_ff.cmd == CH_VAR) && (s_ff.nf == 2'h0)
                     && !s_ff.cur_dig && !s_ff.cur_neg)
            begin
              nxt_s.cur_txt = 1'b1;
            end
            else if ((b == CH_MINUS) && (s_ff.cmd == CH_VAR) && (s_ff.nf == 2'h0)
                     && !s_ff.cur_dig && !s_ff.cur_neg)
            begin
              nxt_s.cur_neg = 1'b1;
            end
            else if (is_digit(b))
            begin
              acc           = 21'(s_ff.cur) * 21'd10 + 21'(b - CH_ZERO);
              nxt_s.cur     = acc[16:0];
              nxt_s.cur_dig = 1'b1;
              if (acc > 21'(VAL_POS_MAX))
              begin
                nxt_s.p_bad = 1'b1;
              end
            end
            else
            begin
              nxt_s.p_bad = 1'b1;
            end
            if (close)
            begin
              if (!s_ff.cur_txt && !s_ff.cur_dig)
              begin
                nxt_s.p_bad = 1'b1;
              end
              if (s_ff.nf == 2'h0)
              begin
                nxt_s.f0     = s_ff.cur;
                nxt_s.f0_neg = s_ff.cur_neg;
                nxt_s.f0_txt = s_ff.cur_txt;
              end
              else if (s_ff.nf == 2'h1)
              begin
                nxt_s.f1 = s_ff.cur;
              end
              else
              begin
                nxt_s.p_bad = 1'b1;
              end
              nxt_s.nf      = (s_ff.nf == 2'h3) ? 2'h3 : s_ff.nf + 2'h1;
              nxt_s.cur     = '0;
              nxt_s.cur_dig = 1'b0;
              nxt_s.cur_neg = 1'b0;
              nxt_s.cur_txt = 1'b0;
              nxt_s.q_pend  = 1'b0;
            end
          end
          default:
          begin
            nxt_s.ps = PS_IDLE;
          end
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // State and packet buffer
  // ----------------------------------------------------------------
  always_ff @(posedge mclk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      s_ff      <= '0;
      s_ff.mode <= MODE_SLAVE;
      s_ff.node <= NODE_RST;
    end
    else
    begin
      s_ff <= nxt_s;
    end
  end

  always_ff @(posedge mclk_i)
  begin
    if (mem_we)
    begin
      pkt_mem[mem_wa] <= rx_byte.data;
    end
  end

  always_ff @(posedge mclk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      disp_rdata_ff <= '0;
    end
    else if (PW'(disp_raddr_i) < PW'(BUF_LEN))
    begin
      disp_rdata_ff <= pkt_mem[PW'(disp_raddr_i)];
    end
    else
    begin
      disp_rdata_ff <= '0;
    end
  end

  assign reg_rdata_o  = s_ff.rdata;
  assign disp_rdata_o = disp_rdata_ff;
  assign slv_evt_o    = s_ff.sevt;
  assign cmd_evt_o    = s_ff.cevt;
  assign var_text_o   = s_ff.txt_out;
  assign lamp_o       = s_ff.lamp;

endmodule : sdcr_top
`default_nettype wire

/* sim/sdcr_top_checker.sv */
`timescale 1ns/1ps
`default_nettype none
module sdcr_top_checker
  import sdcr_pkg::*;
(
  input wire logic          mclk_i,
  input wire logic          rst_i,
  input wire logic          reg_rd_i,
  input wire logic [31:0]   reg_rdata_o,
  input wire sdcr_slv_evt_s slv_evt_o,
  input wire sdcr_cmd_evt_s cmd_evt_o,
  input wire logic [15:0]   lamp_o
);
  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (rst_i);

  chk_rd_idle_zero:
    assert property (!$past(reg_rd_i) |-> reg_rdata_o == 32'h0) else $error("read data outside read cycle");
  chk_trig_one_cycle:
    assert property (cmd_evt_o.trig |=> !cmd_evt_o.trig) else $error("trigger pulse too long");
  chk_msg_bounds:
    assert property (cmd_evt_o.trig |-> cmd_evt_o.msg inside {[14'h0001:14'h270f]}) else $error("message out of range");
  chk_var_one_cycle:
    assert property (cmd_evt_o.var_wr |=> !cmd_evt_o.var_wr) else $error("variable pulse too long");
  chk_slot_bounds:
    assert property (cmd_evt_o.var_wr |-> cmd_evt_o.slot inside {[4'h1:4'ha]}) else $error("slot out of range");
  chk_num_range:
    assert property (cmd_evt_o.var_wr && !cmd_evt_o.is_text |-> !cmd_evt_o.val[16] || cmd_evt_o.val >= 17'h18000)
      else $error("numeric value out of range");
  chk_line_bounds:
    assert property (slv_evt_o.load |-> slv_evt_o.line inside {[3'h1:3'h4]}) else $error("load on bad line");
  chk_clear_all_alone:
    assert property (slv_evt_o.clr_all |-> !slv_evt_o.load && !slv_evt_o.clr_line) else $error("clear all mixed");
  chk_lamp_one_step:
    assert property ($onehot0(lamp_o ^ $past(lamp_o))) else $error("several lamps changed at once");
  chk_mode_apart:
    assert property (cmd_evt_o.trig || cmd_evt_o.var_wr |-> !slv_evt_o.load && !slv_evt_o.clr_line)
      else $error("packet and command events together");
endmodule : sdcr_top_checker
`default_nettype wire

/* sim/sdcr_host_tx.sv */
`timescale 1ns/1ps
`default_nettype none
module sdcr_host_tx
#(
  parameter int DIV = 16
)(
  input  wire logic mclk_i,
  output var  logic txd_o
);
  initial txd_o = 1'b1;
  // frames as the bench orders them, 8N1 LSB first
  task automatic send(input logic [7:0] b, input int gap);
    logic [9:0] fr;
    fr = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++)
    begin
      @(posedge mclk_i);
      txd_o <= fr[i];
      repeat (DIV - 1) @(posedge mclk_i);
    end
    repeat (gap) @(posedge mclk_i);
  endtask : send
endmodule : sdcr_host_tx
`default_nettype wire

/* sim/sdcr_top_test.sv */
`timescale 1ns/1ps
`default_nettype none
module sdcr_top_test
  import sdcr_pkg::*;
;
  localparam int DIV = 16;
  logic          mclk_i;
  logic          rst_i;
  logic          rxd;
  logic [7:0]    addr;
  logic [31:0]   wdata;
  logic          wr_s;
  logic          rd_s;
  logic [31:0]   rdata;
  logic [6:0]    draddr;
  logic [7:0]    drdata;
  sdcr_slv_evt_s slv;
  sdcr_cmd_evt_s cmd;
  logic [127:0]  vtext;
  logic [15:0]   lamp;
  int            n_mismatch;
  int            n_tests;
  int            n_ev;
  int            gap;

  sdcr_top #(.BAUD_DIV(DIV)) i_dut (.mclk_i(mclk_i), .rst_i(rst_i), .rxd_i(rxd), .reg_addr_i(addr),
    .reg_wdata_i(wdata), .reg_wr_i(wr_s), .reg_rd_i(rd_s), .reg_rdata_o(rdata), .disp_raddr_i(draddr),
    .disp_rdata_o(drdata), .slv_evt_o(slv), .cmd_evt_o(cmd), .var_text_o(vtext), .lamp_o(lamp));
  sdcr_host_tx #(.DIV(DIV)) i_host (.mclk_i(mclk_i), .txd_o(rxd));

  initial
  begin
    mclk_i = 1'b0;
    forever #12.5 mclk_i = ~mclk_i;
  end

  always @(posedge mclk_i)
  begin
    if ((slv.load | slv.clr_line | slv.clr_all | cmd.trig | cmd.var_wr) === 1'b1)
      n_ev++;
  end

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk_i);
    addr  <= a;
    wdata <= d;
    wr_s  <= 1'b1;
    @(posedge mclk_i);
    wr_s  <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    @(posedge mclk_i);
    addr <= a;
    rd_s <= 1'b1;
    @(posedge mclk_i);
    rd_s <= 1'b0;
    #1 chk("read data", exp, rdata);
  endtask : rd

  task automatic fin(input int exp);
    i_host.send(CH_CR, 4);
    chk("events", exp, n_ev);
  endtask : fin

  task automatic pkt(input logic [7:0] lead, input string txt, input logic [7:0] node, input logic [7:0] ln,
                     input int exp);
    n_ev = 0;
    if (lead != 8'h00)
      i_host.send(lead, 0);
    for (int i = 0; i < txt.len(); i++)
      i_host.send(txt[i], 0);
    i_host.send(node, 0);
    i_host.send(ln, 0);
    fin(exp);
  endtask : pkt

  task automatic ctl(input logic [7:0] c, input string txt, input int exp);
    n_ev = 0;
    i_host.send(c, gap);
    for (int i = 0; i < txt.len(); i++)
      i_host.send(txt[i], gap);
    fin(exp);
  endtask : ctl

  task automatic t_regs();
    rd(REG_CTRL, 32'h00000100);
    rd(8'h10, 32'h00000000);
    wr(REG_LAMP, 32'h0000ffff);
    rd(REG_LAMP, 32'h00000000);
    $display("t_regs done");
  endtask : t_regs

  task automatic t_slave();
    wr(REG_CTRL, 32'h00000600);
    pkt(8'h00, "A1", 8'h06, 8'h02, 1);
    chk("line", 32'h2, {29'h0, slv.line});
    chk("len", 32'h2, {25'h0, slv.len});
    chk("refresh", 32'h0, {31'h0, slv.vars_only});
    @(posedge mclk_i);
    draddr <= 7'h00;
    @(posedge mclk_i);
    #1 chk("buffer", 32'h41, {24'h0, drdata});
    pkt(8'h00, "AB", 8'h09, 8'h02, 0);
    pkt(8'h00, "A2", 8'h06, 8'h02, 1);
    chk("refresh", 32'h1, {31'h0, slv.vars_only});
    pkt(8'h00, "C", 8'h7f, 8'h01, 1);
    pkt(8'h00, "C", 8'h0d, 8'h01, 0);
    pkt(CH_CLEAR, "", 8'h06, 8'h03, 1);
    chk("clear line", 32'h3, {29'h0, slv.line});
    pkt(CH_CLEAR, "", 8'h06, 8'h32, 1);
    pkt(8'h00, "Z\007!", 8'h06, 8'h01, 0);
    pkt(8'h00, "Z\007 ", 8'h06, 8'h01, 1);
    wr(REG_CTRL, 32'h00007f00);
    pkt(8'h00, "D", 8'h09, 8'h04, 1);
    ctl(CH_TRIG, "24\\127", 0);
    $display("t_slave done");
  endtask : t_slave

  task automatic t_trig();
    wr(REG_CTRL, 32'h00000602);
    ctl(CH_TRIG, "24\\ 6", 1);
    chk("message", 32'd24, {18'h0, cmd.msg});
    ctl(CH_TRIG, "9999\\127", 1);
    ctl(CH_TRIG, "5\\7", 0);
    ctl(CH_TRIG, "10000\\6", 0);
    ctl(CH_TRIG, "5\\", 0);
    pkt(8'h00, "AB", 8'h06, 8'h02, 0);
    rd(REG_TRIG, 32'h0000270f);
    $display("t_trig done");
  endtask : t_trig

  task automatic t_var();
    ctl(CH_VAR, "-32768\\ 10\\ 6", 1);
    chk("value", 32'h18000, {15'h0, cmd.val});
    chk("slot", 32'ha, {28'h0, cmd.slot});
    ctl(CH_VAR, "65535\\1\\6", 1);
    chk("value", 32'h0ffff, {15'h0, cmd.val});
    ctl(CH_VAR, "65536\\1\\6", 0);
    ctl(CH_VAR, "5\\11\\6", 0);
    ctl(CH_VAR, "\"12\"\\2\\6", 1);
    chk("text", 32'h13231, {15'h0, cmd.is_text, vtext[15:0]});
    $display("t_var done");
  endtask : t_var

  task automatic t_lamp();
    gap = 3 * DIV;
    ctl(CH_LAMP, "4\\1\\6", 0);
    chk("lamps", 32'h0008, {16'h0, lamp});
    gap = 0;
    ctl(CH_LAMP, "16\\1\\127", 0);
    ctl(CH_LAMP, "4\\0\\6", 0);
    ctl(CH_LAMP, "17\\1\\6", 0);
    ctl(CH_LAMP, "3\\2\\6", 0);
    rd(REG_LAMP, 32'h00008000);
    wr(REG_CTRL, 32'h00000601);
    ctl(CH_LAMP, "1\\1\\6", 0);
    chk("lamps", 32'h8000, {16'h0, lamp});
    $display("t_lamp done");
  endtask : t_lamp

  task automatic conclude();
    $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : conclude

  initial
  begin
    rst_i = 1'b1;
    addr = 8'h00;
    wdata = 32'h0;
    wr_s = 1'b0;
    rd_s = 1'b0;
    draddr = 7'h00;
    gap = 0;
    repeat (5) @(posedge mclk_i);
    rst_i <= 1'b0;
    t_regs();
    t_slave();
    t_trig();
    t_var();
    t_lamp();
    conclude();
  end

  initial
  begin
    #1500us;
    n_mismatch++;
    conclude();
  end
endmodule : sdcr_top_test

bind sdcr_top sdcr_top_checker i_chk (.mclk_i(mclk_i), .rst_i(rst_i), .reg_rd_i(reg_rd_i),
  .reg_rdata_o(reg_rdata_o), .slv_evt_o(slv_evt_o), .cmd_evt_o(cmd_evt_o), .lamp_o(lamp_o));
`default_nettype wire
